// file: rtl/fpx_map.vh
`ifndef FPX_MAP_VH
`define FPX_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FPX_OFF_CTRL 4'h0
`define FPX_OFF_STATUS 4'h4
`define FPX_OFF_CAUSE 4'h8
`define FPX_OFF_LAST 4'hC

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define FPX_CTRL_LOW_DIS 0
`define FPX_CTRL_HIGH_DIS 1
`define FPX_CTRL_EN_V 2
`define FPX_CTRL_EN_D 3
`define FPX_CTRL_EN_Z 4
`define FPX_CTRL_EN_O 5
`define FPX_CTRL_EN_U 6
`define FPX_CTRL_EN_I 7
`define FPX_CTRL_FTZ 8
`define FPX_CTRL_W 9
`define FPX_CTRL_RST 9'h000

// ----------------------------------------------------------------
// status flag positions (fp_status_word)
// ----------------------------------------------------------------
`define FPX_FLG_V 0
`define FPX_FLG_D 1
`define FPX_FLG_Z 2
`define FPX_FLG_O 3
`define FPX_FLG_U 4
`define FPX_FLG_I 5
`define FPX_FLG_W 6
`define FPX_STATUS_RST 6'h00

// ----------------------------------------------------------------
// interruption_cause_code bit positions
// ----------------------------------------------------------------
`define FPX_CC_V 0
`define FPX_CC_D 1
`define FPX_CC_Z 2
`define FPX_CC_SWA 3
`define FPX_CC_O 11
`define FPX_CC_U 12
`define FPX_CC_I 13
`define FPX_CC_FPA 14
`define FPX_CC_W 16
`define FPX_CC_RST 16'h0000

// ----------------------------------------------------------------
// result selection codes to the datapath
// ----------------------------------------------------------------
`define FPX_RES_NORMAL 3'h0
`define FPX_RES_WRAP 3'h1
`define FPX_RES_INF 3'h2
`define FPX_RES_MAXFIN 3'h3
`define FPX_RES_ZERO 3'h4
`define FPX_RES_DENORM 3'h5
`define FPX_RES_MININT 3'h6
`define FPX_RES_NAN 3'h7

// ----------------------------------------------------------------
// rounding modes and register subset bounds
// ----------------------------------------------------------------
`define FPX_RM_NEAR 2'h0
`define FPX_RM_DOWN 2'h1
`define FPX_RM_UP 2'h2
`define FPX_RM_ZERO 2'h3
`define FPX_LOW_FIRST 7'h02
`define FPX_LOW_LAST 7'h1F
`define FPX_HIGH_FIRST 7'h20

`endif

// file: rtl/fpx_nan_pick.v
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// nan source selection and classification
// ----------------------------------------------------------------
module fpx_nan_pick (
    // operand nan info, index 0 = f2, 1 = f3, 2 = f4
    input wire [2:0] nan_i,
    input wire [2:0] qbit_i,
    // selection
    output reg any_o,
    output reg [1:0] src_o,
    output reg snan_o
);

    always @* begin
        any_o = |nan_i;
        // a clear top fraction bit marks a signalling nan
        snan_o = |(nan_i & ~qbit_i);
        // f4 first, then f2, lastly f3
        if (nan_i[2]) begin
            src_o = 2'h2;
        end else if (nan_i[0]) begin
            src_o = 2'h0;
        end else begin
            src_o = 2'h1;
        end
    end

endmodule

`default_nettype wire

// file: rtl/fpx_exc_unit.v
`timescale 1ns/10ps
`default_nettype none
`include "fpx_map.vh"

module fpx_exc_unit #(
    parameter UNB_W = 19,
    parameter EXP_W = 17,
    parameter PEXP_W = 8,
    parameter RNUM_W = 7,
    parameter NFIELD = 4
) (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // operation from the datapath
    input wire op_valid_i,
    input wire op_arith_i,
    input wire op_parallel_i,
    input wire op_fp2int_i,
    input wire op_sign_i,
    input wire [1:0] op_rmode_i,
    input wire [NFIELD-1:0] reg_use_i,
    input wire [NFIELD*RNUM_W-1:0] reg_num_i,
    input wire nat_opnd_i,
    input wire swa_fault_req_i,
    input wire swa_trap_req_i,
    input wire invalid_i,
    input wire zero_div_i,
    input wire denorm_opnd_i,
    input wire overflow_i,
    input wire tiny_i,
    input wire inexact_i,
    input wire round_incr_i,
    input wire [UNB_W-1:0] exp_unb_i,
    input wire [2:0] nan_opnd_i,
    input wire [2:0] nan_qbit_i,
    // report to interruption logic and datapath
    output reg done_o,
    output reg dfr_fault_o,
    output reg fp_fault_o,
    output reg fp_trap_o,
    output reg [`FPX_CC_W-1:0] cause_code_o,
    output reg result_magnified_o,
    output reg [`FPX_FLG_W-1:0] flag_set_o,
    output reg [2:0] res_sel_o,
    output reg [EXP_W-1:0] res_exp_o,
    output reg [1:0] nan_src_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [`FPX_CTRL_W-1:0] ctrl_reg;
    reg [`FPX_FLG_W-1:0] status_reg;
    reg [`FPX_CC_W-1:0] last_cc_reg;
    reg [2:0] last_kind_reg;

    wire low_fpreg_disable = ctrl_reg[`FPX_CTRL_LOW_DIS];
    wire high_fpreg_disable = ctrl_reg[`FPX_CTRL_HIGH_DIS];
    wire en_v = ctrl_reg[`FPX_CTRL_EN_V];
    wire en_d = ctrl_reg[`FPX_CTRL_EN_D];
    wire en_z = ctrl_reg[`FPX_CTRL_EN_Z];
    wire en_o = ctrl_reg[`FPX_CTRL_EN_O];
    wire en_u = ctrl_reg[`FPX_CTRL_EN_U];
    wire en_i = ctrl_reg[`FPX_CTRL_EN_I];
    wire ftz = ctrl_reg[`FPX_CTRL_FTZ];

    // ----------------------------------------------------------------
    // register subset check, one lane per operand field
    // ----------------------------------------------------------------
    wire [NFIELD-1:0] field_dis;
    genvar g;
    generate
        for (g = 0; g < NFIELD; g = g + 1) begin : g_field
            wire [RNUM_W-1:0] num = reg_num_i[g*RNUM_W +: RNUM_W];
            wire in_low = (num >= `FPX_LOW_FIRST) && (num <= `FPX_LOW_LAST);
            wire in_high = (num >= `FPX_HIGH_FIRST);
            // fr0 and fr1 are never gated
            assign field_dis[g] = reg_use_i[g] &
                ((in_low & low_fpreg_disable) | (in_high & high_fpreg_disable));
        end
    endgenerate
    wire dfr_hit = |field_dis;

    // ----------------------------------------------------------------
    // nan operands
    // ----------------------------------------------------------------
    wire nan_any;
    wire nan_snan;
    wire [1:0] nan_src;

    fpx_nan_pick u_nan (
        .nan_i(nan_opnd_i),
        .qbit_i(nan_qbit_i),
        .any_o(nan_any),
        .src_o(nan_src),
        .snan_o(nan_snan)
    );

    // ----------------------------------------------------------------
    // exception evaluation
    // ----------------------------------------------------------------
    reg dfr_next;
    reg fault_next;
    reg [`FPX_CC_W-1:0] cc_next;
    reg [`FPX_FLG_W-1:0] flg_next;
    reg [2:0] res_next;
    reg fpa_next;
    reg sig_inv;
    reg use_inf;
    reg [`FPX_CC_W-1:0] tcc;

    wire [EXP_W-1:0] exp_wrap = op_parallel_i ?
        {{(EXP_W-PEXP_W){1'b0}}, exp_unb_i[PEXP_W-1:0]} : exp_unb_i[EXP_W-1:0];

    always @* begin
        dfr_next = 1'b0;
        fault_next = 1'b0;
        cc_next = `FPX_CC_RST;
        flg_next = {`FPX_FLG_W{1'b0}};
        res_next = `FPX_RES_NORMAL;
        fpa_next = 1'b0;
        tcc = `FPX_CC_RST;
        sig_inv = invalid_i | nan_snan;
        // infinity unless the rounding direction points toward zero
        use_inf = (op_rmode_i == `FPX_RM_NEAR) ||
                  ((op_rmode_i == `FPX_RM_UP) && !op_sign_i) ||
                  ((op_rmode_i == `FPX_RM_DOWN) && op_sign_i);
        if (dfr_hit) begin
            dfr_next = 1'b1;
        end else if (op_arith_i) begin
            // faults leave the status flags alone
            if (sig_inv && en_v) begin
                fault_next = 1'b1;
                cc_next[`FPX_CC_V] = 1'b1;
            end else if (sig_inv) begin
                flg_next[`FPX_FLG_V] = 1'b1;
                res_next = op_fp2int_i ? `FPX_RES_MININT : `FPX_RES_NAN;
            end else if (zero_div_i && en_z) begin
                fault_next = 1'b1;
                cc_next[`FPX_CC_Z] = 1'b1;
            end else if (zero_div_i) begin
                flg_next[`FPX_FLG_Z] = 1'b1;
                res_next = `FPX_RES_INF;
            end else if (denorm_opnd_i && en_d) begin
                fault_next = 1'b1;
                cc_next[`FPX_CC_D] = 1'b1;
            end else if (swa_fault_req_i && !nat_opnd_i) begin
                // assist only taken when no not-a-thing operand is present
                fault_next = 1'b1;
                cc_next[`FPX_CC_SWA] = 1'b1;
            end else if (nan_any) begin
                // lower exceptions are suppressed behind a nan
                flg_next[`FPX_FLG_D] = denorm_opnd_i;
                res_next = `FPX_RES_NAN;
            end else begin
                flg_next[`FPX_FLG_D] = denorm_opnd_i;
                fpa_next = round_incr_i;
                if (overflow_i) begin
                    flg_next[`FPX_FLG_O] = 1'b1;
                    if (en_o) begin
                        res_next = `FPX_RES_WRAP;
                        tcc[`FPX_CC_O] = 1'b1;
                        tcc[`FPX_CC_I] = inexact_i;
                        flg_next[`FPX_FLG_I] = inexact_i;
                    end else begin
                        flg_next[`FPX_FLG_I] = 1'b1;
                        res_next = use_inf ? `FPX_RES_INF : `FPX_RES_MAXFIN;
                        fpa_next = use_inf;
                        tcc[`FPX_CC_I] = en_i;
                    end
                end else if (tiny_i) begin
                    if (ftz) begin
                        res_next = `FPX_RES_ZERO;
                        flg_next[`FPX_FLG_U] = 1'b1;
                        flg_next[`FPX_FLG_I] = 1'b1;
                        fpa_next = 1'b0;
                        tcc[`FPX_CC_U] = en_u;
                        tcc[`FPX_CC_I] = en_i;
                    end else if (en_u) begin
                        flg_next[`FPX_FLG_U] = 1'b1;
                        res_next = `FPX_RES_WRAP;
                        tcc[`FPX_CC_U] = 1'b1;
                        tcc[`FPX_CC_I] = inexact_i;
                        flg_next[`FPX_FLG_I] = inexact_i;
                    end else begin
                        res_next = `FPX_RES_DENORM;
                        flg_next[`FPX_FLG_U] = inexact_i;
                        flg_next[`FPX_FLG_I] = inexact_i;
                        tcc[`FPX_CC_I] = inexact_i & en_i;
                    end
                end else if (inexact_i) begin
                    flg_next[`FPX_FLG_I] = 1'b1;
                    tcc[`FPX_CC_I] = en_i;
                end
                // assist trap names a disabled trap, result is its enabled response
                if (swa_trap_req_i && !(ftz && tiny_i) && (tcc == `FPX_CC_RST)) begin
                    if (overflow_i) begin
                        tcc[`FPX_CC_O] = 1'b1;
                        res_next = `FPX_RES_WRAP;
                        fpa_next = round_incr_i;
                    end else if (tiny_i) begin
                        tcc[`FPX_CC_U] = 1'b1;
                        res_next = `FPX_RES_WRAP;
                    end else begin
                        tcc[`FPX_CC_I] = 1'b1;
                    end
                end
                if (tcc != `FPX_CC_RST) begin
                    cc_next = tcc;
                    cc_next[`FPX_CC_FPA] = fpa_next;
                end
            end
        end
    end

    wire trap_next = (cc_next != `FPX_CC_RST) && !fault_next && !dfr_next;

    // ----------------------------------------------------------------
    // report registers
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
            dfr_fault_o <= 1'b0;
            fp_fault_o <= 1'b0;
            fp_trap_o <= 1'b0;
            cause_code_o <= `FPX_CC_RST;
            result_magnified_o <= 1'b0;
            flag_set_o <= `FPX_STATUS_RST;
            res_sel_o <= `FPX_RES_NORMAL;
            res_exp_o <= {EXP_W{1'b0}};
            nan_src_o <= 2'h0;
        end else if (ce_i) begin
            done_o <= op_valid_i;
            if (op_valid_i) begin
                dfr_fault_o <= dfr_next;
                fp_fault_o <= fault_next;
                fp_trap_o <= trap_next;
                cause_code_o <= cc_next;
                result_magnified_o <= trap_next & fpa_next;
                flag_set_o <= flg_next;
                res_sel_o <= res_next;
                res_exp_o <= exp_wrap;
                nan_src_o <= nan_src;
            end else begin
                // report strobes are single cycle
                dfr_fault_o <= 1'b0;
                fp_fault_o <= 1'b0;
                fp_trap_o <= 1'b0;
                flag_set_o <= `FPX_STATUS_RST;
            end
        end
    end

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_ctrl = bus_req & wb_we_i & (wb_adr_i == `FPX_OFF_CTRL);
    wire wr_stat = bus_req & wb_we_i & (wb_adr_i == `FPX_OFF_STATUS) & wb_sel_i[0];
    wire [`FPX_FLG_W-1:0] stat_clr = wr_stat ? wb_dat_i[`FPX_FLG_W-1:0] : {`FPX_FLG_W{1'b0}};
    wire [`FPX_FLG_W-1:0] stat_set = (op_valid_i && !dfr_next) ? flg_next : `FPX_STATUS_RST;
    // set beats a write-one clear that lands in the same cycle
    wire [`FPX_FLG_W-1:0] status_next = (status_reg & ~stat_clr) | stat_set;
    reg [31:0] rd_next;

    always @* begin
        case (wb_adr_i)
            `FPX_OFF_CTRL: rd_next = {{(32-`FPX_CTRL_W){1'b0}}, ctrl_reg};
            `FPX_OFF_STATUS: rd_next = {{(32-`FPX_FLG_W){1'b0}}, status_reg};
            `FPX_OFF_CAUSE: rd_next = {16'h0000, last_cc_reg};
            `FPX_OFF_LAST: rd_next = {29'h00000000, last_kind_reg};
            default: rd_next = 32'h00000000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl_reg <= `FPX_CTRL_RST;
            status_reg <= `FPX_STATUS_RST;
            last_cc_reg <= `FPX_CC_RST;
            last_kind_reg <= 3'h0;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? rd_next : 32'h00000000;
            if (wr_ctrl && wb_sel_i[0]) begin
                ctrl_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wr_ctrl && wb_sel_i[1]) begin
                ctrl_reg[`FPX_CTRL_FTZ] <= wb_dat_i[`FPX_CTRL_FTZ];
            end
            status_reg <= status_next;
            if (op_valid_i && (dfr_next || fault_next || trap_next)) begin
                last_cc_reg <= cc_next;
                last_kind_reg <= {trap_next, fault_next, dfr_next};
            end
        end
    end

endmodule

`default_nettype wire

// file: bench/fpx_exc_unit_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpx_map.vh"

module fpx_exc_unit_props #(
    parameter UNB_W = 19,
    parameter EXP_W = 17,
    parameter PEXP_W = 8
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // operation side
    input wire logic op_valid_i,
    input wire logic op_arith_i,
    input wire logic op_parallel_i,
    input wire logic [UNB_W-1:0] exp_unb_i,
    // report side
    input wire logic done_o,
    input wire logic dfr_fault_o,
    input wire logic fp_fault_o,
    input wire logic fp_trap_o,
    input wire logic [`FPX_CC_W-1:0] cause_code_o,
    input wire logic result_magnified_o,
    input wire logic [`FPX_FLG_W-1:0] flag_set_o,
    input wire logic [EXP_W-1:0] res_exp_o
);
    logic [UNB_W-1:0] exp_d;
    logic par_d;

    // exponent of the op just taken, lined up with its answer cycle
    always @(posedge clk_i) begin
        exp_d <= exp_unb_i;
        par_d <= op_parallel_i;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    AST_BUS_ACK: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");
    AST_DONE_LAT: assert property (op_valid_i && ce_i |=> done_o)
        else $error("done missing one cycle after op");
    AST_DONE_ONLY: assert property (!op_valid_i && ce_i |=> !done_o)
        else $error("done without op");
    AST_NONARITH: assert property (
        op_valid_i && ce_i && !op_arith_i |=> !fp_fault_o && !fp_trap_o)
        else $error("non-arithmetic op raised fault or trap");
    AST_DFR_FIRST: assert property (
        dfr_fault_o |-> !fp_fault_o && !fp_trap_o && flag_set_o == 6'h00)
        else $error("register fault not exclusive");
    AST_FAULT_QUIET: assert property (
        fp_fault_o |-> flag_set_o == 6'h00 && !fp_trap_o)
        else $error("exception fault changed flags or trapped");
    AST_MAG_TRAP: assert property (
        $rose(result_magnified_o) |-> fp_trap_o && cause_code_o[`FPX_CC_FPA])
        else $error("magnified shown without trap");
    AST_EVENT_DONE: assert property (
        dfr_fault_o || fp_fault_o || fp_trap_o || flag_set_o != 6'h00 |-> done_o)
        else $error("event pulse outside done cycle");
    AST_EXP_FULL: assert property (
        op_valid_i && ce_i && !op_parallel_i |=> !par_d && res_exp_o == exp_d[EXP_W-1:0])
        else $error("exponent not wrapped to full width");
    AST_EXP_PAR: assert property (
        op_valid_i && ce_i && op_parallel_i |=>
        res_exp_o == {{(EXP_W-PEXP_W){1'b0}}, exp_d[PEXP_W-1:0]})
        else $error("parallel exponent not wrapped");
endmodule

`default_nettype wire

// file: bench/fpx_dp_model.sv
`timescale 1ns/10ps
`default_nettype none

module fpx_dp_model (
    // request from the bench
    input wire logic go_i,
    input wire logic [21:0] cfg_i,
    input wire logic [27:0] num_i,
    input wire logic [18:0] exp_i,
    // operation port of the block
    output logic valid_o,
    output logic [21:0] attr_o,
    output logic [3:0] use_o,
    output logic [27:0] num_o,
    output logic [18:0] exp_o
);
    // ----------------------------------------------------------------
    // qualifiers flip outside the valid cycle
    // ----------------------------------------------------------------
    // a block that looks at them without op_valid_i cannot pass by luck
    assign valid_o = go_i;
    assign attr_o = go_i ? cfg_i : ~cfg_i;
    assign use_o = go_i ? 4'h2 : 4'hD;
    assign num_o = go_i ? num_i : ~num_i;
    assign exp_o = go_i ? exp_i : ~exp_i;
endmodule

`default_nettype wire

// file: bench/fpx_exc_unit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpx_map.vh"

module fpx_exc_unit_tb_top;
    localparam logic [21:0] AR = 22'h1, PAR = 22'h2, F2I = 22'h4, SGN = 22'h8, RZ = 22'h30;
    localparam logic [21:0] NAT = 22'h40, SWF = 22'h80, SWT = 22'h100, INV = 22'h200;
    localparam logic [21:0] ZD = 22'h400, DEN = 22'h800, OVF = 22'h1000, TINY = 22'h2000;
    localparam logic [21:0] INX = 22'h4000, INC = 22'h8000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic go = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rq;
    logic [21:0] cfg = 22'h0;
    logic [27:0] num = 28'h0;
    logic [18:0] ex = 19'h0;
    integer fails = 0;
    integer total_checks = 0;
    wire logic ack, done, dfr, flt, trp, mag, opv;
    wire logic [31:0] rdat;
    wire logic [15:0] cc;
    wire logic [5:0] flg;
    wire logic [2:0] rsel;
    wire logic [16:0] rexp;
    wire logic [1:0] nsrc;
    wire logic [21:0] attr;
    wire logic [3:0] usew;
    wire logic [27:0] numw;
    wire logic [18:0] expw;

    always #50 clk_i = ~clk_i;

    fpx_dp_model model (.go_i(go), .cfg_i(cfg), .num_i(num), .exp_i(ex), .valid_o(opv),
        .attr_o(attr), .use_o(usew), .num_o(numw), .exp_o(expw));

    fpx_exc_unit dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .op_valid_i(opv), .op_arith_i(attr[0]),
        .op_parallel_i(attr[1]), .op_fp2int_i(attr[2]), .op_sign_i(attr[3]),
        .op_rmode_i(attr[5:4]), .reg_use_i(usew), .reg_num_i(numw), .nat_opnd_i(attr[6]),
        .swa_fault_req_i(attr[7]), .swa_trap_req_i(attr[8]), .invalid_i(attr[9]),
        .zero_div_i(attr[10]), .denorm_opnd_i(attr[11]), .overflow_i(attr[12]),
        .tiny_i(attr[13]), .inexact_i(attr[14]), .round_incr_i(attr[15]), .exp_unb_i(expw),
        .nan_opnd_i(attr[18:16]), .nan_qbit_i(attr[21:19]), .done_o(done),
        .dfr_fault_o(dfr), .fp_fault_o(flt), .fp_trap_o(trp), .cause_code_o(cc),
        .result_magnified_o(mag), .flag_set_o(flg), .res_sel_o(rsel), .res_exp_o(rexp),
        .nan_src_o(nsrc));

    // ----------------------------------------------------------------
    // bus, operation and compare tasks
    // ----------------------------------------------------------------
    task close_out;
        begin
            $display("checks %0d fails %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        integer n;
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            sel <= s;
            n = 0;
            @(posedge clk_i);
            while (ack !== 1'b1 && n < 20) begin
                @(posedge clk_i);
                n = n + 1;
            end
            rq = rdat;
            // released address and data lines show the inverse, never the stale value; we and sel keep theirs
            cyc <= 1'b0;
            adr <= ~a;
            wdat <= ~d;
            if (n >= 20) begin
                fails = fails + 1;
                $display("[FAIL] %0t bus answer timed out", $time);
                close_out;
            end
        end
    endtask

    task rd(input logic [3:0] a, input logic [31:0] e);
        begin
            wb(1'b0, a, 32'h0, 4'hF);
            chk(rq, e);
        end
    endtask

    task ctl(input logic [31:0] d);
        begin
            wb(1'b1, `FPX_OFF_CTRL, d, 4'hF);
        end
    endtask

    // fl[6] set skips the flag compare
    task do_op(input logic [21:0] c, input logic [6:0] rn, input logic [18:0] e,
        input logic [2:0] ev, input logic [6:0] fl);
        begin
            @(posedge clk_i);
            go <= 1'b1;
            cfg <= c;
            ex <= e;
            num <= {14'h0, rn, 7'h0};
            @(posedge clk_i);
            go <= 1'b0;
            @(posedge clk_i);
            chk({done, dfr, flt, trp}, {1'b1, ev});
            if (!fl[6]) chk(flg, fl[5:0]);
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
        begin
            rd(`FPX_OFF_CTRL, 32'h0);
            rd(`FPX_OFF_STATUS, 32'h0);
            rd(`FPX_OFF_CAUSE, 32'h0);
            rd(`FPX_OFF_LAST, 32'h0);
            wb(1'b1, `FPX_OFF_CAUSE, 32'hFFFF, 4'hF);
            rd(`FPX_OFF_CAUSE, 32'h0);
            wb(1'b1, `FPX_OFF_CTRL, 32'h1FF, 4'h1);
            rd(`FPX_OFF_CTRL, 32'hFF);
        end
    endtask

    task t_dfr;
        logic [6:0] rns [0:4];
        integer i, j;
        logic f;
        begin
            rns = '{7'h01, 7'h02, 7'h1F, 7'h20, 7'h7F};
            for (j = 1; j < 3; j++) begin
                ctl(32'h4 | j);
                for (i = 0; i < 5; i++) begin
                    f = (j == 1) ? (rns[i] >= 2 && rns[i] <= 31) : (rns[i] >= 32);
                    do_op(AR | INV, rns[i], 19'h0, f ? 3'h4 : 3'h2, 7'h00);
                    do_op(INV, rns[i], 19'h0, f ? 3'h4 : 3'h0, 7'h00);
                end
            end
        end
    endtask

    task t_fault;
        logic [31:0] cs [0:3];
        logic [21:0] cf [0:3];
        integer i;
        begin
            cs = '{32'h4, 32'h8, 32'h10, 32'h0};
            cf = '{AR | INV, AR | DEN, AR | ZD, AR | SWF};
            for (i = 0; i < 4; i++) begin
                ctl(cs[i]);
                do_op(cf[i], 7'h0, 19'h0, 3'h2, 7'h00);
                chk(cc, 32'h1 << i);
            end
            do_op(AR | SWF | NAT, 7'h0, 19'h0, 3'h0, 7'h00);
            do_op(AR | F2I | INV, 7'h0, 19'h0, 3'h0, 7'h01);
            chk(rsel, `FPX_RES_MININT);
        end
    endtask

    task t_over;
        begin
            ctl(32'h0);
            do_op(AR | OVF, 7'h0, 19'h54321, 3'h0, 7'h28);
            chk(rsel, `FPX_RES_INF);
            do_op(AR | OVF | RZ, 7'h0, 19'h54321, 3'h0, 7'h28);
            chk(rsel, `FPX_RES_MAXFIN);
            do_op(AR | OVF | SWT, 7'h0, 19'h54321, 3'h1, 7'h40);
            chk({cc, 13'h0, rsel}, {16'h0800, 13'h0, `FPX_RES_WRAP});
            ctl(32'h20);
            do_op(AR | OVF | INX | INC, 7'h0, 19'h54321, 3'h1, 7'h28);
            chk(cc, 32'h6800);
            chk({mag, rsel, rexp}, {1'b1, `FPX_RES_WRAP, 17'h14321});
            do_op(AR | PAR | OVF, 7'h0, 19'h54321, 3'h1, 7'h08);
            chk({mag, rexp}, {1'b0, 17'h00021});
            ctl(32'h80);
            do_op(AR | INX, 7'h0, 19'h0, 3'h1, 7'h20);
            chk(cc, 32'h2000);
        end
    endtask

    task t_under;
        begin
            ctl(32'h0);
            do_op(AR | TINY, 7'h0, 19'h0, 3'h0, 7'h00);
            chk(rsel, `FPX_RES_DENORM);
            do_op(AR | TINY | INX, 7'h0, 19'h0, 3'h0, 7'h30);
            ctl(32'h40);
            do_op(AR | TINY, 7'h0, 19'h7FF00, 3'h1, 7'h10);
            chk(cc, 32'h1000);
            chk({rsel, rexp}, {`FPX_RES_WRAP, 17'h1FF00});
            ctl(32'h100);
            do_op(AR | TINY | SWT | SGN, 7'h0, 19'h0, 3'h0, 7'h30);
            chk(rsel, `FPX_RES_ZERO);
        end
    endtask

    task t_nan;
        logic [2:0] nm [0:2];
        logic [1:0] es [0:2];
        integer i;
        begin
            nm = '{3'h7, 3'h3, 3'h2};
            es = '{2'h2, 2'h0, 2'h1};
            ctl(32'h0);
            for (i = 0; i < 3; i++) begin
                do_op({3'h7, nm[i], 16'h0001}, 7'h0, 19'h0, 3'h0, 7'h00);
                chk({rsel, nsrc}, {`FPX_RES_NAN, es[i]});
            end
            ctl(32'h4);
            do_op({3'h6, 3'h1, 16'h0001}, 7'h0, 19'h0, 3'h2, 7'h00);
            do_op({3'h7, 3'h1, 16'h0001}, 7'h0, 19'h0, 3'h0, 7'h00);
        end
    endtask

    task t_status;
        begin
            ctl(32'h0);
            wb(1'b1, `FPX_OFF_STATUS, 32'h3F, 4'h1);
            do_op(AR | F2I | INV, 7'h0, 19'h0, 3'h0, 7'h01);
            rd(`FPX_OFF_STATUS, 32'h01);
            ctl(32'h4);
            do_op(AR | F2I | INV, 7'h0, 19'h0, 3'h2, 7'h00);
            rd(`FPX_OFF_STATUS, 32'h01);
            wb(1'b1, `FPX_OFF_STATUS, 32'h01, 4'h1);
            rd(`FPX_OFF_STATUS, 32'h0);
        end
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_dfr;
        t_fault;
        t_over;
        t_under;
        t_nan;
        t_status;
        close_out;
    end
endmodule

bind fpx_exc_unit fpx_exc_unit_props #(.UNB_W(UNB_W), .EXP_W(EXP_W), .PEXP_W(PEXP_W)) props (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .op_valid_i(op_valid_i), .op_arith_i(op_arith_i),
    .op_parallel_i(op_parallel_i), .exp_unb_i(exp_unb_i), .done_o(done_o),
    .dfr_fault_o(dfr_fault_o), .fp_fault_o(fp_fault_o), .fp_trap_o(fp_trap_o),
    .cause_code_o(cause_code_o), .result_magnified_o(result_magnified_o),
    .flag_set_o(flag_set_o), .res_exp_o(res_exp_o));

`default_nettype wire
